// ---- dsl_flasher.sv ----
// Purpose: free-running on/off phase generator for one flash pattern
// Assumes: both phase lengths are at least one cycle
// Notes: phase_out is registered, reset low, and follows the on phase of count from the first edge
`timescale 1ns/1ps
module dsl_flasher #(
    parameter int HIGH_CYC = 2,
    parameter int LOW_CYC = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic phase_out
);
    localparam int TOTAL = HIGH_CYC + LOW_CYC;
    localparam int CNT_W = $clog2(TOTAL);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TOTAL - 1);
    localparam logic [CNT_W-1:0] HIGH_END = CNT_W'(HIGH_CYC);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (HIGH_CYC < 1 || LOW_CYC < 1)
    begin : g_bad
        $error("dsl_flasher: phase lengths must be at least one cycle");
    end

    // ------------------------------------------------------------------
    // period counter
    // ------------------------------------------------------------------
    always_comb
    begin
        if (count == LAST)
        begin
            next_count = '0;
        end
        else
        begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_out <= 1'b0;
        end
        else
        begin
            phase_out <= (next_count < HIGH_END);
        end
    end

endmodule : dsl_flasher

// ---- dsl_lamp_encoder.sv ----
// Purpose: encode drive and fieldbus state onto three bicolour lamps
// Assumes: state inputs synchronous to clk_in; bus select set before use
// Notes: AXI4-Lite slave holds control and a read-only status word
//
// Operation
// - drive three green/red lamps: drive status, bus status, bus fault.
// - drive lamp flashes green when healthy and output stage disabled.
// - drive lamp steady green when healthy and output stage enabled.
// - drive lamp flashes red on fault; output stage forced disabled.
// - drive lamp dark when unpowered or defective, and off after reset.
// - CANopen pre-operational: bus status lamp flashes green rapidly.
// - CANopen operational: bus status lamp steady green.
// - CANopen stopped: bus status lamp flashes green slowly.
// - EtherCAT init: bus status lamp dark.
// - EtherCAT pre-operational: bus status lamp flashes green slowly.
// - EtherCAT safe-operational: bus status lamp gives repeated single flashes.
// - EtherCAT operational: bus status lamp steady green.
// - EtherCAT bootstrap: bus status lamp flashes green rapidly.
// - PROFINET: status lamp dark until ready, then flashes green.
// - CANopen/EtherCAT: fault lamp dark when healthy, red when defective.
// - PROFINET fault lamp: dark active, red no link, flashing red idle.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module dsl_lamp_encoder #(
    parameter int SLOW_HALF_CYC = dsl_pkg::SLOW_HALF_CYC,
    parameter int RAPID_HALF_CYC = dsl_pkg::RAPID_HALF_CYC,
    parameter int SINGLE_ON_CYC = dsl_pkg::SINGLE_ON_CYC,
    parameter int SINGLE_OFF_CYC = dsl_pkg::SINGLE_OFF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dsl_pkg::dsl_drive_t drive_in,
    input wire dsl_pkg::dsl_fieldbus_t fieldbus_in,
    input wire logic [dsl_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [dsl_pkg::DATA_W-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [dsl_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [dsl_pkg::DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic stage_enable_out,
    output dsl_pkg::dsl_lamp_t drive_status_lamp_out,
    output dsl_pkg::dsl_lamp_t bus_status_lamp_out,
    output dsl_pkg::dsl_lamp_t bus_fault_lamp_out
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (RAPID_HALF_CYC < 1 || RAPID_HALF_CYC >= SLOW_HALF_CYC)
    begin : g_bad_rate
        $error("dsl_lamp_encoder: rapid flash must be faster than slow");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } dsl_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } dsl_rd_state_t;

    dsl_wr_state_t wr_state;
    dsl_wr_state_t next_wr_state;
    dsl_rd_state_t rd_state;
    dsl_rd_state_t next_rd_state;
    logic aw_got;
    logic w_got;
    logic next_aw_got;
    logic next_w_got;
    logic aw_take;
    logic w_take;
    logic wr_commit;
    logic [dsl_pkg::ADDR_W-1:0] wr_addr;
    logic [dsl_pkg::DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [2:0] ctrl;
    dsl_pkg::dsl_bus_sel_t bus_sel;
    logic stage_req;
    logic slow_phase;
    logic rapid_phase;
    logic single_phase;
    dsl_pkg::dsl_pat_t drv_pat;
    dsl_pkg::dsl_pat_t bus_pat;
    dsl_pkg::dsl_pat_t flt_pat;
    logic drv_red;
    logic flt_on;
    logic drv_on;
    logic bus_on;
    logic [dsl_pkg::DATA_W-1:0] status_word;

    function automatic logic pat_on(input dsl_pkg::dsl_pat_t pat);
        case (pat)
            dsl_pkg::PAT_STEADY: pat_on = 1'b1;
            dsl_pkg::PAT_SLOW: pat_on = slow_phase;
            dsl_pkg::PAT_RAPID: pat_on = rapid_phase;
            dsl_pkg::PAT_SINGLE: pat_on = single_phase;
            default: pat_on = 1'b0;
        endcase
    endfunction : pat_on

    // ------------------------------------------------------------------
    // flash timebases
    // ------------------------------------------------------------------
    dsl_flasher #(.HIGH_CYC(SLOW_HALF_CYC), .LOW_CYC(SLOW_HALF_CYC)) u_slow (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(slow_phase)
    );

    dsl_flasher #(.HIGH_CYC(RAPID_HALF_CYC), .LOW_CYC(RAPID_HALF_CYC)) u_rapid (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(rapid_phase)
    );

    dsl_flasher #(.HIGH_CYC(SINGLE_ON_CYC), .LOW_CYC(SINGLE_OFF_CYC)) u_single (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(single_phase)
    );

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && s_axi_wready_out;
    assign wr_commit = (wr_state == WR_IDLE) && aw_got && w_got;

    always_comb
    begin
        next_wr_state = wr_state;
        next_aw_got = aw_got || aw_take;
        next_w_got = w_got || w_take;
        case (wr_state)
            WR_IDLE:
            begin
                if (wr_commit)
                begin
                    next_wr_state = WR_RESP;
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready_in)
                begin
                    next_wr_state = WR_IDLE;
                end
            end
            default:
            begin
                next_wr_state = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_state <= WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
        end
        else
        begin
            wr_state <= next_wr_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_awready_out <= (next_wr_state == WR_IDLE) && !next_aw_got;
            s_axi_wready_out <= (next_wr_state == WR_IDLE) && !next_w_got;
            s_axi_bvalid_out <= (next_wr_state == WR_RESP);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                wr_addr <= s_axi_awaddr_in;
            end
            if (w_take)
            begin
                wr_data <= s_axi_wdata_in;
                wr_strb <= s_axi_wstrb_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_bresp_out <= dsl_pkg::RESP_OKAY;
        end
        else if (wr_commit)
        begin
            if (wr_addr == dsl_pkg::ADDR_CTRL || wr_addr == dsl_pkg::ADDR_STATUS)
            begin
                s_axi_bresp_out <= dsl_pkg::RESP_OKAY;
            end
            else
            begin
                s_axi_bresp_out <= dsl_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // select is meant to be static; changing it live just swaps tables
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl <= dsl_pkg::CTRL_RESET;
        end
        else if (wr_commit && wr_addr == dsl_pkg::ADDR_CTRL && wr_strb[0])
        begin
            ctrl <= wr_data[2:0];
        end
    end

    assign bus_sel = dsl_pkg::dsl_bus_sel_t'(ctrl[dsl_pkg::CTRL_SEL_MSB:dsl_pkg::CTRL_SEL_LSB]);
    assign stage_req = ctrl[dsl_pkg::CTRL_STAGE_BIT];

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    always_comb
    begin
        status_word = '0;
        status_word[dsl_pkg::ST_OK_BIT] = drive_in.ok;
        status_word[dsl_pkg::ST_FAULT_BIT] = drive_in.fault;
        status_word[dsl_pkg::ST_STAGE_BIT] = stage_enable_out;
        status_word[dsl_pkg::ST_DRV_LSB +: 2] = drive_status_lamp_out;
        status_word[dsl_pkg::ST_BUS_LSB +: 2] = bus_status_lamp_out;
        status_word[dsl_pkg::ST_BFLT_LSB +: 2] = bus_fault_lamp_out;
        status_word[dsl_pkg::ST_SEL_LSB +: 2] = bus_sel;
    end

    always_comb
    begin
        next_rd_state = rd_state;
        case (rd_state)
            RD_IDLE:
            begin
                if (s_axi_arvalid_in && s_axi_arready_out)
                begin
                    next_rd_state = RD_DATA;
                end
            end
            RD_DATA:
            begin
                if (s_axi_rready_in)
                begin
                    next_rd_state = RD_IDLE;
                end
            end
            default:
            begin
                next_rd_state = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_state <= RD_IDLE;
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
        end
        else
        begin
            rd_state <= next_rd_state;
            s_axi_arready_out <= (next_rd_state == RD_IDLE);
            s_axi_rvalid_out <= (next_rd_state == RD_DATA);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= dsl_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_rresp_out <= dsl_pkg::RESP_OKAY;
            if (s_axi_araddr_in == dsl_pkg::ADDR_CTRL)
            begin
                s_axi_rdata_out <= {29'h0, ctrl};
            end
            else if (s_axi_araddr_in == dsl_pkg::ADDR_STATUS)
            begin
                s_axi_rdata_out <= status_word;
            end
            else
            begin
                s_axi_rdata_out <= '0;
                s_axi_rresp_out <= dsl_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // output stage gate
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage_enable_out <= 1'b0;
        end
        else
        begin
            stage_enable_out <= stage_req && drive_in.ok && !drive_in.fault;
        end
    end

    // ------------------------------------------------------------------
    // pattern tables
    // ------------------------------------------------------------------
    always_comb
    begin
        drv_red = 1'b0;
        drv_pat = dsl_pkg::PAT_OFF;
        if (drive_in.fault)
        begin
            drv_red = 1'b1;
            drv_pat = dsl_pkg::PAT_SLOW;
        end
        else if (drive_in.ok && stage_enable_out)
        begin
            drv_pat = dsl_pkg::PAT_STEADY;
        end
        else if (drive_in.ok)
        begin
            drv_pat = dsl_pkg::PAT_SLOW;
        end
    end

    always_comb
    begin
        bus_pat = dsl_pkg::PAT_OFF;
        flt_pat = dsl_pkg::PAT_OFF;
        case (bus_sel)
            dsl_pkg::BUS_CANOPEN:
            begin
                case (fieldbus_in.can_state)
                    dsl_pkg::CAN_PREOP: bus_pat = dsl_pkg::PAT_RAPID;
                    dsl_pkg::CAN_OP: bus_pat = dsl_pkg::PAT_STEADY;
                    dsl_pkg::CAN_STOPPED: bus_pat = dsl_pkg::PAT_SLOW;
                    default: bus_pat = dsl_pkg::PAT_OFF;
                endcase
                if (fieldbus_in.can_fault)
                begin
                    flt_pat = dsl_pkg::PAT_STEADY;
                end
            end
            dsl_pkg::BUS_ETHERCAT:
            begin
                case (fieldbus_in.ecat_state)
                    dsl_pkg::ECAT_INIT: bus_pat = dsl_pkg::PAT_OFF;
                    dsl_pkg::ECAT_PREOP: bus_pat = dsl_pkg::PAT_SLOW;
                    dsl_pkg::ECAT_SAFEOP: bus_pat = dsl_pkg::PAT_SINGLE;
                    dsl_pkg::ECAT_OP: bus_pat = dsl_pkg::PAT_STEADY;
                    dsl_pkg::ECAT_BOOT: bus_pat = dsl_pkg::PAT_RAPID;
                    default: bus_pat = dsl_pkg::PAT_OFF;
                endcase
                if (fieldbus_in.ecat_fault)
                begin
                    flt_pat = dsl_pkg::PAT_STEADY;
                end
            end
            dsl_pkg::BUS_PROFINET:
            begin
                if (fieldbus_in.pn_ready)
                begin
                    bus_pat = dsl_pkg::PAT_SLOW;
                end
                if (!fieldbus_in.pn_connected)
                begin
                    flt_pat = dsl_pkg::PAT_STEADY;
                end
                else if (!fieldbus_in.pn_io_active)
                begin
                    flt_pat = dsl_pkg::PAT_SLOW;
                end
            end
            default:
            begin
                bus_pat = dsl_pkg::PAT_OFF;
            end
        endcase
    end

    always_comb
    begin
        drv_on = pat_on(drv_pat);
        bus_on = pat_on(bus_pat);
        flt_on = pat_on(flt_pat);
    end

    // ------------------------------------------------------------------
    // lamp drivers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            drive_status_lamp_out <= '0;
            bus_status_lamp_out <= '0;
            bus_fault_lamp_out <= '0;
        end
        else
        begin
            // one colour at a time; red and green never lit together
            drive_status_lamp_out.red <= drv_red && drv_on;
            drive_status_lamp_out.green <= !drv_red && drv_on;
            bus_status_lamp_out.red <= 1'b0;
            bus_status_lamp_out.green <= bus_on;
            bus_fault_lamp_out.red <= flt_on;
            bus_fault_lamp_out.green <= 1'b0;
        end
    end

endmodule : dsl_lamp_encoder

// ---- dsl_lamp_encoder_sva.sv ----
// Purpose: port checks for the lamp encoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes: lamps lag their causes by one edge
`timescale 1ns/1ps
module dsl_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dsl_pkg::dsl_drive_t drive_in,
    input wire dsl_pkg::dsl_fieldbus_t fieldbus_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic stage_enable_out,
    input wire dsl_pkg::dsl_lamp_t drive_status_lamp_out,
    input wire dsl_pkg::dsl_lamp_t bus_status_lamp_out,
    input wire dsl_pkg::dsl_lamp_t bus_fault_lamp_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_red_wins; drive_in.fault |=> !drive_status_lamp_out.green; endproperty
    a_red_wins: assert property (p_red_wins) else $error("green during fault");
    property p_dark; !drive_in.ok && !drive_in.fault |=> drive_status_lamp_out == 2'h0; endproperty
    a_dark: assert property (p_dark) else $error("drive lamp lit");
    property p_stage; stage_enable_out |-> $past(drive_in.ok && !drive_in.fault); endproperty
    a_stage: assert property (p_stage) else $error("stage on while faulty");
    property p_steady; drive_in.ok && !drive_in.fault && stage_enable_out |=> drive_status_lamp_out == 2'h1; endproperty
    a_steady: assert property (p_steady) else $error("drive lamp not steady");
    property p_red_src; drive_status_lamp_out.red |-> $past(drive_in.fault); endproperty
    a_red_src: assert property (p_red_src) else $error("red without fault");
    property p_colours; !bus_status_lamp_out.red && !bus_fault_lamp_out.green; endproperty
    a_colours: assert property (p_colours) else $error("bus lamp wrong colour");
    property p_bus_red; bus_fault_lamp_out.red |-> $past(fieldbus_in.can_fault ||
        fieldbus_in.ecat_fault || !(fieldbus_in.pn_connected && fieldbus_in.pn_io_active)); endproperty
    a_bus_red: assert property (p_bus_red) else $error("fault lamp without cause");
    property p_bresp; s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out; endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    c_red: cover property (drive_status_lamp_out.red);
    c_steady: cover property (drive_status_lamp_out == 2'h1);
    c_bus_red: cover property (bus_fault_lamp_out.red);
endmodule : dsl_chk
bind dsl_lamp_encoder dsl_chk u_chk (.*);

// ---- dsl_lamp_panel.sv ----
// Purpose: model of the three bicolour lamps, counting lit cycles
// Assumes: lamp colours sampled on the rising edge of clk_in
// Notes: counts only mean something over whole flash periods
`timescale 1ns/1ps
module dsl_lamp_panel (
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic [3:0] lit_in,
    output logic [3:0][15:0] on_cnt_out,
    output logic [3:0][15:0] rise_cnt_out
);
    logic [3:0] prev;
    always_ff @(posedge clk_in)
    begin
        prev <= lit_in;
        for (int i = 0; i < 4; i++)
        begin
            on_cnt_out[i] <= clear_in ? 16'h0 : on_cnt_out[i] + 16'(lit_in[i]);
            rise_cnt_out[i] <= clear_in ? 16'h0 : rise_cnt_out[i] + 16'(lit_in[i] & ~prev[i]);
        end
    end
endmodule : dsl_lamp_panel

// ---- dsl_pkg.sv ----
// Purpose: shared constants and types of the drive status lamp encoder
// Assumes: 20 MHz logic clock, AXI4-Lite register access with 32-bit data
// Notes: flash times are free choices; the lamp patterns derive from them
package dsl_pkg;

    // ------------------------------------------------------------------
    // clock and flash timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int SLOW_HALF_MS = 500;
    localparam int RAPID_HALF_MS = 100;
    localparam int SINGLE_ON_MS = 200;
    localparam int SINGLE_OFF_MS = 1000;
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
    localparam int RAPID_HALF_CYC = RAPID_HALF_MS * CYC_PER_MS;
    localparam int SINGLE_ON_CYC = SINGLE_ON_MS * CYC_PER_MS;
    localparam int SINGLE_OFF_CYC = SINGLE_OFF_MS * CYC_PER_MS;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_MSB = 1;
    localparam int CTRL_STAGE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int ST_OK_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_STAGE_BIT = 2;
    localparam int ST_DRV_LSB = 4;
    localparam int ST_BUS_LSB = 6;
    localparam int ST_BFLT_LSB = 8;
    localparam int ST_SEL_LSB = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_CANOPEN = 2'h0,
        BUS_ETHERCAT = 2'h1,
        BUS_PROFINET = 2'h2,
        BUS_NONE = 2'h3
    } dsl_bus_sel_t;

    typedef enum logic [1:0] {
        CAN_INIT = 2'h0,
        CAN_PREOP = 2'h1,
        CAN_OP = 2'h2,
        CAN_STOPPED = 2'h3
    } dsl_can_state_t;

    typedef enum logic [2:0] {
        ECAT_INIT = 3'h0,
        ECAT_PREOP = 3'h1,
        ECAT_SAFEOP = 3'h2,
        ECAT_OP = 3'h3,
        ECAT_BOOT = 3'h4
    } dsl_ecat_state_t;

    typedef enum logic [2:0] {
        PAT_OFF = 3'h0,
        PAT_STEADY = 3'h1,
        PAT_SLOW = 3'h2,
        PAT_RAPID = 3'h3,
        PAT_SINGLE = 3'h4
    } dsl_pat_t;

    typedef struct packed {
        logic red;
        logic green;
    } dsl_lamp_t;

    typedef struct packed {
        logic ok;
        logic fault;
    } dsl_drive_t;

    typedef struct packed {
        dsl_can_state_t can_state;
        logic can_fault;
        dsl_ecat_state_t ecat_state;
        logic ecat_fault;
        logic pn_ready;
        logic pn_connected;
        logic pn_io_active;
    } dsl_fieldbus_t;

endpackage : dsl_pkg

// ---- tb.sv ----
// Purpose: table-driven bench for the lamp encoder
// Assumes: short flash parameters, AXI4-Lite master tasks
// Notes: window of 240 cycles spans whole periods of every pattern
`timescale 1ns/1ps
module tb;
    localparam int SL = 8, RP = 2, SO = 3, SF = 12, W = 240;
    localparam logic [31:0] OFF = 32'h0, STEADY = {16'(W), 16'h0};
    localparam logic [31:0] SLOW = {16'(W / 2), 16'(W / (2 * SL))};
    localparam logic [31:0] RAPID = {16'(W / 2), 16'(W / (2 * RP))};
    localparam logic [31:0] SINGLE = {16'(W * SO / (SO + SF)), 16'(W / (SO + SF))};
    // ctrl, drive {ok,fault}, fieldbus, lamp, expected {lit cycles, turn-ons}
    localparam logic [49:0] STEPS [20] = '{
        {4'h0,2'h0,10'h000,2'h0,OFF}, {4'h0,2'h2,10'h000,2'h0,SLOW},
        {4'h4,2'h2,10'h000,2'h0,STEADY}, {4'h4,2'h3,10'h000,2'h1,SLOW},
        {4'h4,2'h2,10'h140,2'h2,RAPID}, {4'h4,2'h2,10'h240,2'h2,STEADY},
        {4'h4,2'h2,10'h340,2'h2,SLOW}, {4'h4,2'h2,10'h3C0,2'h3,STEADY},
        {4'h5,2'h2,10'h380,2'h3,OFF}, {4'h5,2'h2,10'h380,2'h2,OFF},
        {4'h5,2'h2,10'h390,2'h2,SLOW}, {4'h5,2'h2,10'h3A0,2'h2,SINGLE},
        {4'h5,2'h2,10'h3B0,2'h2,STEADY}, {4'h5,2'h2,10'h3C0,2'h2,RAPID},
        {4'h5,2'h2,10'h3C8,2'h3,STEADY}, {4'h6,2'h2,10'h3C8,2'h2,OFF},
        {4'h6,2'h2,10'h3C8,2'h3,STEADY}, {4'h6,2'h2,10'h3CE,2'h2,SLOW},
        {4'h6,2'h2,10'h3CE,2'h3,SLOW}, {4'h6,2'h2,10'h3CF,2'h3,OFF}};
    logic clk_in = 1'b0, rst_n_in = 1'b0, clear = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hF;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, stage_enable_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    dsl_pkg::dsl_drive_t drive_in = '0;
    dsl_pkg::dsl_fieldbus_t fieldbus_in = '0;
    dsl_pkg::dsl_lamp_t drive_status_lamp_out, bus_status_lamp_out, bus_fault_lamp_out;
    logic [3:0][15:0] on_cnt, rise_cnt;
    int num_errors = 0, checks = 0;
    dsl_lamp_encoder #(.SLOW_HALF_CYC(SL), .RAPID_HALF_CYC(RP), .SINGLE_ON_CYC(SO),
        .SINGLE_OFF_CYC(SF)) DUT (.*);
    // lamps 0 drive green, 1 drive red, 2 bus green, 3 bus fault red
    dsl_lamp_panel u_panel (.clk_in, .clear_in(clear), .lit_in({bus_fault_lamp_out.red,
        bus_status_lamp_out.green, drive_status_lamp_out.red, drive_status_lamp_out.green}),
        .on_cnt_out(on_cnt), .rise_cnt_out(rise_cnt));
    initial forever #25 clk_in = ~clk_in;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        num_errors += int'(seen !== exp);
        if (seen !== exp)
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    endtask : check
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic axi_write(input logic [3:0] addr, input logic [31:0] data);
        s_axi_awaddr_in <= addr;
        s_axi_wdata_in <= data;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do @(posedge clk_in); while (!(s_axi_awready_out && s_axi_wready_out));
        s_axi_awvalid_in <= 1'b0;
        s_axi_wvalid_in <= 1'b0;
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_in); while (!s_axi_bvalid_out);
        s_axi_bready_in <= 1'b0;
        check("write resp", 32'(s_axi_bresp_out), 32'(dsl_pkg::RESP_OKAY));
    endtask : axi_write
    task automatic axi_read(input logic [3:0] addr, input logic [1:0] resp, output logic [31:0] data);
        s_axi_araddr_in <= addr;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge clk_in); while (!s_axi_rvalid_out);
        s_axi_rready_in <= 1'b0;
        data = s_axi_rdata_out;
        check("read resp", 32'(s_axi_rresp_out), 32'(resp));
    endtask : axi_read
    task automatic measure(input logic [1:0] ch, input logic [31:0] exp);
        repeat (6) @(posedge clk_in);
        clear <= 1'b1;
        @(posedge clk_in);
        clear <= 1'b0;
        repeat (W + 1) @(posedge clk_in);
        check("lamp pattern", {on_cnt[ch], rise_cnt[ch]}, exp);
    endtask : measure
    initial
    begin
        #1_000_000;
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        axi_read(dsl_pkg::ADDR_CTRL, dsl_pkg::RESP_OKAY, rd);
        check("ctrl reset", rd, 32'h0);
        axi_read(4'h8, dsl_pkg::RESP_SLVERR, rd);
        check("unmapped read", rd, 32'h0);
        for (int i = 0; i < 20; i++)
        begin
            axi_write(dsl_pkg::ADDR_CTRL, 32'(STEPS[i][49:46]));
            drive_in <= STEPS[i][45:44];
            fieldbus_in <= STEPS[i][43:34];
            measure(STEPS[i][33:32], STEPS[i][31:0]);
            $display("step %0d done", i);
        end
        stop_test();
    end
endmodule : tb
